// *** src/oscr_defs.vh ***
`ifndef OSCR_DEFS_VH
`define OSCR_DEFS_VH
// =====================================================================
// register map (byte addresses)
`define OSCR_ADDR_CTRL      4'h0
`define OSCR_ADDR_CTRL2     4'h4
`define OSCR_ADDR_STATUS    4'h8
`define OSCR_ADDR_CLEAR     4'hc
// =====================================================================
// oscillator_control fields
`define OSCR_IDLE_BIT       7
`define OSCR_FREQ_HI        6
`define OSCR_FREQ_LO        4
`define OSCR_TIMEOUT_BIT    3
`define OSCR_HF_STABLE_BIT  2
`define OSCR_SRC_HI         1
`define OSCR_SRC_LO         0
// oscillator_control_second fields
`define OSCR_DRIVE_BIT      2
`define OSCR_HF_LOCK_BIT    1
`define OSCR_LF_STABLE_BIT  0
// low-frequency source select lives above the eight-bit register
`define OSCR_LF_SRC_BIT     8
// interrupt enable register sits in the upper bits of the status word
`define OSCR_IRQ_EN_LO      8
// =====================================================================
// reset values and encodings
`define OSCR_FREQ_RESET     3'h3
`define OSCR_FREQ_31K       3'h0
`define OSCR_SRC_RESET      2'h0
`define OSCR_SRC_PRIMARY    2'h0
`define OSCR_SRC_SECONDARY  2'h1
`define OSCR_EVT_W          3
// =====================================================================
// axi responses
`define OSCR_RESP_OKAY      2'h0
`define OSCR_RESP_SLVERR    2'h2
`endif

// *** src/oscr_switch.v ***
`timescale 1ns/10ps
`include "oscr_defs.vh"
// =====================================================================
// source switch sequencer: old source stays until the new one is ready
module oscr_switch (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire [1:0] req_src_in,
	input  wire [2:0] req_freq_in,
	input  wire       req_lf_sel_in,
	input  wire [2:0] ready_in,
	output reg  [1:0] active_src_out,
	output reg  [2:0] active_freq_out,
	output reg        active_lf_sel_out,
	output wire       busy_out,
	output reg        done_out
);
	localparam ST_RUN  = 2'b01;
	localparam ST_WAIT = 2'b10;
	reg [1:0] state;
	reg       target_ready;
	wire      differs;
	assign differs = (req_src_in != active_src_out) ||
		(req_freq_in != active_freq_out) ||
		(req_lf_sel_in != active_lf_sel_out);
	assign busy_out = state[1];
	// readiness of the requested source: 0 primary, 1 secondary, 2 internal
	always @* begin
		if (req_src_in[1])
			target_ready = ready_in[2];
		else
			target_ready = ready_in[req_src_in[0]];
	end
	// hold the old selection until the new one reports ready
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state             <= ST_RUN;
			active_src_out    <= `OSCR_SRC_RESET;
			active_freq_out   <= `OSCR_FREQ_RESET;
			active_lf_sel_out <= 1'b0;
			done_out          <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state)
			ST_RUN: begin
				if (differs)
					state <= ST_WAIT;
			end
			ST_WAIT: begin
				if (target_ready) begin
					active_src_out    <= req_src_in;
					active_freq_out   <= req_freq_in;
					active_lf_sel_out <= req_lf_sel_in;
					done_out          <= 1'b1;
					state             <= ST_RUN;
				end
			end
			default: state <= ST_RUN;
			endcase
		end
	end
endmodule // oscr_switch

// *** src/oscr_regs.v ***
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "oscr_defs.vh"
// Function
// - sleep enters idle when idle bit set, full sleep when clear; resets 0
// - three-bit select picks internal output from 16 MHz down to 31 kHz
// - at 000 the 31 kHz clock comes from the low-frequency source select
// - frequency select resets to 011, giving 1 MHz
// - timeout status reads 1 on primary clock, 0 on internal oscillator
// - timeout status reset value follows two-speed start-up configuration
// - high-frequency stable flag mirrors oscillator stability, resets 0
// - source select: 1x internal, 01 secondary, 00 primary; resets 00
// - drive bit 1 turns primary drive on, 0 off; resets 1
// - upper five bits of second register read zero
// - primary drive stays on while primary is the system clock
// - 31 kHz with source bit clear comes from low-frequency oscillator
// - switch sources only when new source is ready, old kept meanwhile
module oscr_regs (
	input  wire        clk_in,
	input  wire        rst_n_in,
	// axi4-lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// configuration and oscillator status
	input  wire        two_speed_startup_cfg_in,
	input  wire        primary_sw_control_cfg_in,
	input  wire        primary_ready_in,
	input  wire        secondary_ready_in,
	input  wire        hf_stable_in,
	input  wire        hf_lock_in,
	input  wire        lf_stable_in,
	input  wire        sleep_exec_in,
	// clock control outputs
	output reg  [1:0]  sys_clock_source_out,
	output reg  [2:0]  internal_freq_out,
	output reg         use_lf_internal_out,
	output reg         primary_drive_en_out,
	output reg         enter_idle_out,
	output reg         enter_sleep_out,
	output wire        irq_out
);
	// =================================================================
	// status pin synchronisers, three stages, change when 2 and 3 agree
	wire [4:0] raw_pins;
	reg  [4:0] sync1;
	reg  [4:0] sync2;
	reg  [4:0] sync3;
	reg  [4:0] pin_q;
	assign raw_pins = {lf_stable_in, hf_lock_in, hf_stable_in,
		secondary_ready_in, primary_ready_in};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clk_in) begin
				if (!rst_n_in) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					sync1[gi] <= raw_pins[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						pin_q[gi] <= sync3[gi];
				end
			end
		end
	endgenerate
	wire prim_rdy;
	wire sec_rdy;
	wire hf_stable;
	wire hf_locked;
	wire lf_stable;
	assign prim_rdy  = pin_q[0];
	assign sec_rdy   = pin_q[1];
	assign hf_stable = pin_q[2];
	assign hf_locked = pin_q[3];
	assign lf_stable = pin_q[4];
	// =================================================================
	// software registers
	reg       idle_on_sleep_sel;
	reg [2:0] internal_freq_sel;
	reg [1:0] sys_clock_source_sel;
	reg       primary_drive_on;
	reg       low_freq_source_sel;
	reg       startup_timeout_status;
	reg       first_cycle;
	reg [`OSCR_EVT_W-1:0] irq_status;
	reg [`OSCR_EVT_W-1:0] irq_enable;
	// =================================================================
	// axi write channel: address and data accepted separately, write done once both are held
	reg        aw_held;
	reg        w_held;
	reg [3:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       do_write;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 4'h0;
			w_data       <= 32'h0;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `OSCR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `OSCR_ADDR_CTRL ||
				    aw_addr == `OSCR_ADDR_CTRL2 ||
				    aw_addr == `OSCR_ADDR_STATUS ||
				    aw_addr == `OSCR_ADDR_CLEAR)
					s_axi_bresp <= `OSCR_RESP_OKAY;
				else
					s_axi_bresp <= `OSCR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	wire wr_ctrl;
	wire wr_ctrl2;
	wire wr_en;
	wire wr_clr;
	wire wr_ctrl2_hi;
	assign wr_ctrl  = do_write && aw_addr == `OSCR_ADDR_CTRL && w_strb[0];
	assign wr_ctrl2 = do_write && aw_addr == `OSCR_ADDR_CTRL2 && w_strb[0];
	assign wr_en    = do_write && aw_addr == `OSCR_ADDR_STATUS && w_strb[1];
	assign wr_clr   = do_write && aw_addr == `OSCR_ADDR_CLEAR && w_strb[0];
	assign wr_ctrl2_hi = do_write && aw_addr == `OSCR_ADDR_CTRL2 && w_strb[1];
	// =================================================================
	// writable control fields; status bits have no write path
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			idle_on_sleep_sel    <= 1'b0;
			internal_freq_sel    <= `OSCR_FREQ_RESET;
			sys_clock_source_sel <= `OSCR_SRC_RESET;
			primary_drive_on     <= 1'b1;
			low_freq_source_sel  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				idle_on_sleep_sel    <= w_data[`OSCR_IDLE_BIT];
				internal_freq_sel    <=
					w_data[`OSCR_FREQ_HI:`OSCR_FREQ_LO];
				sys_clock_source_sel <=
					w_data[`OSCR_SRC_HI:`OSCR_SRC_LO];
			end
			if (wr_ctrl2)
				primary_drive_on <= w_data[`OSCR_DRIVE_BIT];
			// kept out of bits 7-3 so those read zero
			if (wr_ctrl2_hi)
				low_freq_source_sel <= w_data[`OSCR_LF_SRC_BIT];
		end
	end
	// =================================================================
	// clock switch sequencer
	wire [1:0] act_src;
	wire [2:0] act_freq;
	wire       act_lf_sel;
	wire       sw_busy;
	wire       sw_done;
	oscr_switch u_switch (
		.clk_in            (clk_in),
		.rst_n_in          (rst_n_in),
		.req_src_in        (sys_clock_source_sel),
		.req_freq_in       (internal_freq_sel),
		.req_lf_sel_in     (low_freq_source_sel),
		.ready_in          ({hf_stable | lf_stable, sec_rdy, prim_rdy}),
		.active_src_out    (act_src),
		.active_freq_out   (act_freq),
		.active_lf_sel_out (act_lf_sel),
		.busy_out          (sw_busy),
		.done_out          (sw_done)
	);
	// =================================================================
	// timeout status: reset value from two-speed start-up strap
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			first_cycle            <= 1'b1;
			startup_timeout_status <= 1'b0;
		end else begin
			first_cycle <= 1'b0;
			if (first_cycle)
				startup_timeout_status <= !two_speed_startup_cfg_in;
			else if (sw_done)
				startup_timeout_status <= !act_src[1];
		end
	end
	// =================================================================
	// clock control outputs
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sys_clock_source_out <= `OSCR_SRC_RESET;
			internal_freq_out    <= `OSCR_FREQ_RESET;
			use_lf_internal_out  <= 1'b0;
			primary_drive_en_out <= 1'b1;
			enter_idle_out       <= 1'b0;
			enter_sleep_out      <= 1'b0;
		end else begin
			sys_clock_source_out <= act_src;
			internal_freq_out    <= act_freq;
			use_lf_internal_out  <= act_freq == `OSCR_FREQ_31K &&
				!act_lf_sel;
			primary_drive_en_out <= primary_drive_on ||
				!primary_sw_control_cfg_in ||
				act_src == `OSCR_SRC_PRIMARY;
			enter_idle_out  <= sleep_exec_in && idle_on_sleep_sel;
			enter_sleep_out <= sleep_exec_in && !idle_on_sleep_sel;
		end
	end
	// =================================================================
	// interrupts: switch done, hf lost stability, hf lost lock
	reg hf_stable_d;
	reg hf_locked_d;
	wire [`OSCR_EVT_W-1:0] events;
	assign events = {hf_locked_d & ~hf_locked,
		hf_stable_d & ~hf_stable, sw_done};
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			hf_stable_d <= 1'b0;
			hf_locked_d <= 1'b0;
			irq_status  <= {`OSCR_EVT_W{1'b0}};
			irq_enable  <= {`OSCR_EVT_W{1'b0}};
		end else begin
			hf_stable_d <= hf_stable;
			hf_locked_d <= hf_locked;
			// set wins over clear
			irq_status <= (irq_status &
				~(wr_clr ? w_data[`OSCR_EVT_W-1:0] :
				{`OSCR_EVT_W{1'b0}})) | events;
			if (wr_en)
				irq_enable <= w_data[`OSCR_IRQ_EN_LO +:
					`OSCR_EVT_W];
		end
	end
	assign irq_out = |(irq_status & irq_enable);
	// =================================================================
	// axi read channel
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `OSCR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `OSCR_RESP_OKAY;
			case (s_axi_araddr)
			`OSCR_ADDR_CTRL: s_axi_rdata <= {24'h0, idle_on_sleep_sel,
				internal_freq_sel, startup_timeout_status,
				hf_stable, sys_clock_source_sel};
			`OSCR_ADDR_CTRL2: s_axi_rdata <= {22'h0, sw_busy,
				low_freq_source_sel, 5'h0,
				primary_drive_on, hf_locked, lf_stable};
			`OSCR_ADDR_STATUS: s_axi_rdata <= {21'h0, irq_enable,
				5'h0, irq_status};
			`OSCR_ADDR_CLEAR: s_axi_rdata <= 32'h0;
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `OSCR_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // oscr_regs

// *** dv/oscr_regs_assertions.sv ***
`timescale 1ns/10ps
// ================
// port-level checks on the oscillator control registers
module oscr_regs_checker (
	input logic       clk_in,
	input logic       rst_n_in,
	input logic       s_axi_awready,
	input logic       s_axi_wready,
	input logic       s_axi_arready,
	input logic       s_axi_bvalid,
	input logic       s_axi_bready,
	input logic       s_axi_rvalid,
	input logic       s_axi_rready,
	input logic       sleep_exec_in,
	input logic [1:0] sys_clock_source_out,
	input logic [2:0] internal_freq_out,
	input logic       use_lf_internal_out,
	input logic       primary_drive_en_out,
	input logic       enter_idle_out,
	input logic       enter_sleep_out,
	input logic       irq_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	rst_outs_a:
	assert property ($rose(rst_n_in) |-> sys_clock_source_out == 2'h0
		&& internal_freq_out == 3'h3 && primary_drive_en_out && !irq_out)
		else $error("outputs not at reset values");
	sleep_mode_a:
	assert property (sleep_exec_in |=> enter_idle_out != enter_sleep_out)
		else $error("sleep gave no single mode pulse");
	no_mode_a:
	assert property (!sleep_exec_in |=> !enter_idle_out && !enter_sleep_out)
		else $error("mode pulse without sleep");
	drive_kept_a:
	assert property (sys_clock_source_out == 2'h0 |-> primary_drive_en_out)
		else $error("primary drive off while primary runs");
	lf_only_a:
	assert property (use_lf_internal_out |-> internal_freq_out == 3'h0)
		else $error("low-frequency source outside 31 kHz");
	bresp_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rresp_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
	write_block_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_block_a:
	assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");

	idle_c: cover property (enter_idle_out);
	lf_c: cover property (use_lf_internal_out);
	drive_c: cover property (!primary_drive_en_out);
	irq_c: cover property (irq_out);
endmodule // oscr_regs_checker

bind oscr_regs oscr_regs_checker u_oscr_regs_checker (.*);

// *** dv/oscr_regs_tb_top.sv ***
`timescale 1ns/10ps
`include "oscr_defs.vh"
// ================
// self-checking bench for the oscillator control registers
module oscr_regs_tb_top;
	logic        clk_in, rst_n_in, sleep_exec_in;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, w, r;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
	logic        s_axi_arvalid, s_axi_rready, s_axi_rvalid;
	logic        s_axi_awready, s_axi_wready, s_axi_arready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sys_clock_source_out, rsp, src;
	logic [2:0]  internal_freq_out, f;
	logic        two_speed_startup_cfg_in, primary_sw_control_cfg_in;
	logic        primary_ready_in, secondary_ready_in, hf_stable_in;
	logic        hf_lock_in, lf_stable_in, use_lf_internal_out;
	logic        primary_drive_en_out, enter_idle_out;
	logic        enter_sleep_out, irq_out;
	logic [31:0] seed = 32'ha39c;
	int          num_errors = 0, n_checks = 0, i, k;

	oscr_regs u_oscr_regs (.*);

	// ================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// status bits of the control word come from hardware, not the write
	function automatic logic [7:0] ctrl_exp(logic [7:0] v, logic t, logic h);
		return {v[7:4], t, h, v[1:0]};
	endfunction
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task tmo(input int n);
		if (n >= 40) begin
			num_errors++;
			print_verdict;
		end
	endtask
	// one write: address and data offered together, each released when taken
	task wr(input logic [3:0] a, input logic [31:0] v);
		logic pa, pw, ha, hw, hb;
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pw = 1;
		for (int j = 0; j < 99; j++) begin
			@(negedge clk_in);
			ha = pa && s_axi_awready;
			hw = pw && s_axi_wready;
			hb = s_axi_bvalid;
			@(posedge clk_in);
			if (ha) begin
				s_axi_awvalid <= 0;
				pa = 0;
			end
			if (hw) begin
				s_axi_wvalid <= 0;
				pw = 0;
			end
			if (hb) begin
				s_axi_bready <= 0;
				return;
			end
		end
		tmo(99);
	endtask
	// one read: data and response taken at the rvalid edge
	task rd(input logic [3:0] a, output logic [31:0] v);
		logic pa, ha, hr;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		pa = 1;
		for (int j = 0; j < 99; j++) begin
			@(negedge clk_in);
			ha = pa && s_axi_arready;
			hr = s_axi_rvalid;
			if (hr) begin
				v = s_axi_rdata;
				rsp = s_axi_rresp;
			end
			@(posedge clk_in);
			if (ha) begin
				s_axi_arvalid <= 0;
				pa = 0;
			end
			if (hr) begin
				s_axi_rready <= 0;
				return;
			end
		end
		tmo(99);
	endtask

	// ================
	// 40 MHz clock
	initial begin
		clk_in = 0;
		forever #12.5 clk_in = ~clk_in;
	end

	// ================
	// main sequence
	initial begin
		{rst_n_in, sleep_exec_in, s_axi_awvalid, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		{two_speed_startup_cfg_in, secondary_ready_in, hf_stable_in} = 0;
		{hf_lock_in, lf_stable_in} = 0;
		{primary_sw_control_cfg_in, primary_ready_in} = 2'h3;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1;
		rd(`OSCR_ADDR_CTRL, d);
		chk("ctrl_rst", 8'h38, d[7:0]);
		rd(`OSCR_ADDR_CTRL2, d);
		chk("ctrl2_rst", 3'h4, d[2:0]);
		$display("test reset done");
		for (k = 0; k < 2; k++) begin
			wr(`OSCR_ADDR_CTRL, {24'h0, k[0], 7'h30});
			@(posedge clk_in);
			sleep_exec_in <= 1;
			@(posedge clk_in);
			sleep_exec_in <= 0;
			@(negedge clk_in);
			chk("idle", k[0], enter_idle_out);
			chk("sleep", !k[0], enter_sleep_out);
		end
		$display("test sleep done");
		@(posedge clk_in);
		{hf_stable_in, hf_lock_in, lf_stable_in} <= 3'h7;
		for (k = 0; k < 9; k++) begin
			r = xs();
			f = k[2:0];
			w = {24'h0, r[7], f, r[3:2], 1'b1, r[0]};
			src = w[1:0];
			if (k == 8) wr(`OSCR_ADDR_CTRL2, 32'h104);
			wr(`OSCR_ADDR_CTRL, w);
			@(negedge clk_in);
			for (i = 0; i < 40 && internal_freq_out !== f; i++) @(negedge clk_in);
			tmo(i);
			chk("freq", f, internal_freq_out);
			chk("src", src, sys_clock_source_out);
			chk("lf", f == 3'h0 && k < 8, use_lf_internal_out);
			rd(`OSCR_ADDR_CTRL, d);
			chk("ctrl_rb", ctrl_exp(w[7:0], 0, 1), d[7:0]);
		end
		$display("test freq done");
		wr(`OSCR_ADDR_CTRL2, 32'h100);
		@(negedge clk_in);
		for (i = 0; i < 40 && primary_drive_en_out; i++) @(negedge clk_in);
		chk("drive_off", 0, primary_drive_en_out);
		rd(`OSCR_ADDR_CTRL2, d);
		chk("ctrl2_st", 3'h3, d[2:0]);
		chk("ctrl2_rsv", 0, d[7:3]);
		chk("lf_src_rb", 1, d[8]);
		@(posedge clk_in);
		primary_ready_in <= 0;
		wr(`OSCR_ADDR_CTRL, 32'h30);
		repeat (20) @(negedge clk_in);
		chk("src_hold", src, sys_clock_source_out);
		// drive bit stays off: primary selection alone must keep drive on
		wr(`OSCR_ADDR_CTRL2, 32'h100);
		@(posedge clk_in);
		primary_ready_in <= 1;
		@(negedge clk_in);
		for (i = 0; i < 40 && sys_clock_source_out !== 0; i++) @(negedge clk_in);
		tmo(i);
		chk("drive_on", 1, primary_drive_en_out);
		rd(`OSCR_ADDR_CTRL, d);
		chk("tmo_st", 1, d[3]);
		@(posedge clk_in);
		secondary_ready_in <= 1;
		wr(`OSCR_ADDR_CTRL, 32'h31);
		@(negedge clk_in);
		for (i = 0; i < 40 && sys_clock_source_out !== 1; i++) @(negedge clk_in);
		chk("src_sec", `OSCR_SRC_SECONDARY, sys_clock_source_out);
		$display("test switch done");
		wr(`OSCR_ADDR_STATUS, 32'h100);
		@(negedge clk_in);
		chk("irq_on", 1, irq_out);
		wr(`OSCR_ADDR_CLEAR, 32'h7);
		rd(`OSCR_ADDR_STATUS, d);
		chk("evt_clr", 0, d[2:0]);
		chk("irq_off", 0, irq_out);
		wr(`OSCR_ADDR_CTRL, 32'h30);
		@(negedge clk_in);
		for (i = 0; i < 40 && irq_out !== 1; i++) @(negedge clk_in);
		chk("irq_evt", 1, irq_out);
		wr(`OSCR_ADDR_STATUS, 32'h0);
		@(negedge clk_in);
		chk("irq_mask", 0, irq_out);
		rd(`OSCR_ADDR_STATUS, d);
		chk("sticky", 1, d[0]);
		rd(4'h2, d);
		chk("unmapped", `OSCR_RESP_SLVERR, rsp);
		$display("test irq done");
		// second reset with two-speed start-up strapped on
		@(posedge clk_in);
		rst_n_in <= 0;
		two_speed_startup_cfg_in <= 1;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1;
		rd(`OSCR_ADDR_CTRL, d);
		chk("tmo_strap", 0, d[3]);
		chk("src_rst2", `OSCR_SRC_RESET, d[1:0]);
		$display("test strap done");
		print_verdict;
	end
endmodule // oscr_regs_tb_top
